// ### bench/mrs_supply_model.sv
// Supply rail and external reset driver facing the sequencer
`timescale 1ns/1ps
module mrs_supply_model (
    // Clock
    input wire logic aclk,
    // Driven lines
    output logic supply_ok,
    output logic rst_pin
);
    // ------------------------------------------------------------
    // Supply and pin control
    // ------------------------------------------------------------
    initial begin
        supply_ok = 1'b1;
        rst_pin = 1'b0;
    end
    // Pin goes high first so the core never runs on a sagging rail
    task automatic drop();
        @(posedge aclk);
        rst_pin <= 1'b1;
        @(posedge aclk);
        supply_ok <= 1'b0;
    endtask : drop
    // Rail back first, pin released only after it has settled
    task automatic restore();
        @(posedge aclk);
        supply_ok <= 1'b1;
        repeat (8) @(posedge aclk);
        rst_pin <= 1'b0;
    endtask : restore
    task automatic pin(input logic v);
        @(posedge aclk);
        rst_pin <= v;
    endtask : pin
endmodule : mrs_supply_model

// ### bench/mrs_top_tb.sv
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module mrs_top_tb;
    import mrs_pkg::*;
    localparam logic [19:0] PMASK = 20'h5a3c1;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, pa_data, prd_data_q;
    logic [31:0] wdata, rdata, rnd, rd;
    logic [1:0] bresp, rresp, rsp;
    logic supply_ok, rst_pin, wake_pin, stop_exec, idle_exec;
    logic state_we, port_we, pa_we, prd_valid_q;
    logic core_reset_q, core_run_q, idle_q, stop_q, osc_enable_q;
    logic [2:0] irq_pending;
    logic [19:0] port_in, port_ff_q;
    mrs_core_state_t state_in, core_state_q;
    mrs_preq_t preq;
    int error_cnt, cmp_count, n;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    mrs_top #(.POR_CYCLES(20), .PORT_SET_MASK(PMASK)) u_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(rnd[2:0]),
        .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(rnd[5:3]), .rvalid, .rready,
        .rdata, .rresp, .supply_ok, .rst_pin, .wake_pin, .stop_exec,
        .idle_exec, .irq_pending, .state_we, .state_in, .port_we,
        .port_in, .pa_we, .pa_data, .preq, .core_reset_q, .core_run_q,
        .idle_q, .stop_q, .osc_enable_q, .core_state_q, .port_ff_q,
        .prd_data_q, .prd_valid_q);
    mrs_supply_model u_sup (.aclk, .supply_ok, .rst_pin);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Movw, and, or on one register, as the core would apply them
    function automatic logic [7:0] pexp(input logic [31:0] r);
        return (r[15:8] & r[23:16]) | r[31:24];
    endfunction : pexp
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_cyc(input int g, input int e);
        cmp_count++;
        if (g != e) begin
            error_cnt++;
            $display("Error %0t: %0d cycles, expected %0d", $time, g, e);
        end
    endtask : chk_cyc
    task automatic end_sim();
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // Both channels offered together; bready held until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int k;
        @(posedge aclk);
        awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        r = bresp;
        bready <= 1'b0;
        if (k >= 100) error_cnt++;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int k;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 100) error_cnt++;
    endtask : axi_rd
    // Start-up wait from the first low cycle of internal reset
    task automatic wait_run();
        #1 n = 0;
        while (core_reset_q !== 1'b0 && n < 3000) begin
            @(posedge aclk); #1; n++;
        end
        n = 0;
        while (core_run_q !== 1'b1 && n < 3000) begin
            @(posedge aclk); #1; n++;
        end
        chk_cyc(n, OSC_WAIT_CYC);
    endtask : wait_run
    task automatic chk_rst();
        chk(core_reset_q, 1'b1);
        chk(core_state_q, CORE_STATE_RST);
        chk(port_ff_q, PMASK);
    endtask : chk_rst

    // ------------------------------------------------------------
    // Watchdog, well beyond the seven start-up waits
    // ------------------------------------------------------------
    initial begin
        #300000;
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, pa_data, port_in, irq_pending} = '0;
        {wake_pin, stop_exec, idle_exec, state_we, port_we, pa_we} = '0;
        state_in = '0; preq = '0; rnd = 32'hce21;
        error_cnt = 0; cmp_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk_rst();
        wait_run();
        // Random core state, then pin reset must wipe it
        rnd = lfsr(rnd);
        @(posedge aclk);
        state_in <= mrs_core_state_t'({rnd, rnd[0]});
        port_in <= rnd[19:0]; state_we <= 1'b1; port_we <= 1'b1;
        @(posedge aclk);
        state_we <= 1'b0; port_we <= 1'b0;
        #1 chk(port_ff_q, rnd[19:0]);
        u_sup.pin(1'b1);
        repeat (2) @(posedge aclk);
        #1 chk(core_reset_q, 1'b0);
        repeat (2) @(posedge aclk);
        #1 chk_rst();
        u_sup.pin(1'b0);
        wait_run();
        // Idle with no interrupt enabled: only a reset ends it, here the pin
        @(posedge aclk);
        idle_exec <= 1'b1; irq_pending <= 3'h7;
        @(posedge aclk);
        idle_exec <= 1'b0;
        repeat (5) @(posedge aclk);
        #1 chk(idle_q, 1'b1);
        u_sup.pin(1'b1);
        repeat (4) @(posedge aclk);
        #1 chk(idle_q, 1'b0);
        u_sup.pin(1'b0);
        irq_pending <= 3'h0;
        wait_run();
        // Stop halts the oscillator; wake waits the full start-up
        @(posedge aclk);
        stop_exec <= 1'b1;
        @(posedge aclk);
        stop_exec <= 1'b0;
        #1 chk(osc_enable_q, 1'b0);
        chk(core_run_q, 1'b0);
        chk(stop_q, 1'b1);
        @(posedge aclk);
        wake_pin <= 1'b1;
        n = 0;
        while (core_run_q !== 1'b1 && n < 3000) begin
            @(posedge aclk); #1; n++;
        end
        chk_cyc(n, OSC_WAIT_CYC);
        wake_pin <= 1'b0;
        // Stop again, this time cancelled by reset
        @(posedge aclk);
        stop_exec <= 1'b1;
        @(posedge aclk);
        stop_exec <= 1'b0;
        u_sup.pin(1'b1);
        repeat (4) @(posedge aclk);
        #1 chk(stop_q, 1'b0);
        u_sup.pin(1'b0);
        wait_run();
        // Peripheral register via the address register
        rnd = lfsr(rnd);
        @(posedge aclk);
        pa_we <= 1'b1; pa_data <= {5'h0, rnd[2:0]};
        @(posedge aclk);
        pa_we <= 1'b0; preq <= '{1'b1, POP_MOVW, rnd[15:8]};
        @(posedge aclk);
        preq <= '{1'b1, POP_AND, rnd[23:16]};
        @(posedge aclk);
        preq <= '{1'b1, POP_OR, rnd[31:24]};
        @(posedge aclk);
        preq <= '{1'b1, POP_MOVR, 8'h00};
        @(posedge aclk);
        preq <= '0;
        #1 chk(prd_valid_q, 1'b1);
        chk(prd_data_q, pexp(rnd));
        axi_rd(ADDR_PADDR, rd, rsp);
        chk(rd[7:0], {5'h0, rnd[2:0]});
        // Software reset over the bus, then unmapped places
        axi_wr(ADDR_CTRL, 32'h1, rsp);
        chk(rsp, RESP_OKAY);
        axi_rd(ADDR_STATUS, rd, rsp);
        chk(rd[0], 1'b1);
        axi_wr(ADDR_CTRL, 32'h0, rsp);
        wait_run();
        axi_rd(ADDR_STATUS, rd, rsp);
        chk(rd[6:0], 7'h12);
        axi_wr(8'h40, rnd, rsp);
        chk(rsp, RESP_SLVERR);
        axi_rd(8'h44, rd, rsp);
        chk(rd, 32'h0);
        chk(rsp, RESP_SLVERR);
        // Supply loss stops the oscillator and holds reset
        u_sup.drop();
        repeat (3) @(posedge aclk);
        #1 chk(osc_enable_q, 1'b0);
        chk(core_reset_q, 1'b1);
        u_sup.restore();
        wait_run();
        end_sim();
    end
endmodule : mrs_top_tb

// ### rtl/mrs_periph_mem.sv
// Peripheral register file with per-register access types
`timescale 1ns/1ps
module mrs_periph_mem
    import mrs_pkg::*;
#(
    parameter int unsigned N = 8,
    parameter logic [N-1:0] WR_MASK = '1,
    parameter logic [N-1:0] RD_MASK = '1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request
    input wire logic req_valid,
    input wire mrs_pop_t req_op,
    input wire logic [$clog2(N)-1:0] req_idx,
    input wire logic [7:0] req_data,
    // Answer
    output logic [7:0] rdata_q,
    output logic rvalid_q
);

    logic [7:0] mem_q [N];
    logic [7:0] mem_d [N];
    logic [7:0] rdata_d;
    logic rvalid_d;

    // Write-only reads as zero; and/or act on the stored value
    always_comb begin
        mem_d = mem_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (req_valid) begin
            unique case (req_op)
                POP_MOVR: begin
                    rvalid_d = 1'b1;
                    rdata_d = RD_MASK[req_idx] ? mem_q[req_idx] : 8'h00;
                end
                POP_MOVW: begin
                    if (WR_MASK[req_idx]) mem_d[req_idx] = req_data;
                end
                POP_AND: begin
                    if (WR_MASK[req_idx]) begin
                        mem_d[req_idx] = mem_q[req_idx] & req_data;
                    end
                end
                POP_OR: begin
                    if (WR_MASK[req_idx]) begin
                        mem_d[req_idx] = mem_q[req_idx] | req_data;
                    end
                end
            endcase
        end
    end

    // Storage and registered read port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N; i++) mem_q[i] <= 8'h00;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

endmodule : mrs_periph_mem

// ### rtl/mrs_pkg.sv
// Shared constants and types for the reset and start-up sequencer
package mrs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned POR_PULSE_US = 50;
    // Cycles per power-on pulse, 50 us at the core clock
    localparam int unsigned POR_PULSE_CYC = POR_PULSE_US * CLK_MHZ;
    localparam int unsigned OSC_WAIT_CYC = 1866;
    localparam int unsigned WAIT_W = 11;
    // Counter load so the first run cycle lands exactly on the wait count
    localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(OSC_WAIT_CYC - 2);
    localparam int unsigned POR_W = 16;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WAIT = 8'h08;
    localparam logic [7:0] ADDR_PADDR = 8'h0c;
    localparam int unsigned CTRL_SWRST_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Core state loaded on reset
    // ------------------------------------------------------------
    typedef struct packed {
        logic [12:0] pc;
        logic [1:0] mem_bank;
        logic reg_bank;
        logic [2:0] sp;
        logic [2:0] int_en;
        logic timer_run;
        logic [7:0] timer_cnt;
        logic timer_flag;
        logic prescaler_select;
    } mrs_core_state_t;

    // All zero: divide-by-32 prescale, stack at location pair 8 and 9
    localparam mrs_core_state_t CORE_STATE_RST = '{
        pc: 13'h0000, mem_bank: 2'h0, reg_bank: 1'h0, sp: 3'h0,
        int_en: 3'h0, timer_run: 1'h0, timer_cnt: 8'h00,
        timer_flag: 1'h0, prescaler_select: 1'h0};
    localparam int unsigned PRESC_DIV_RST = 32;

    // ------------------------------------------------------------
    // Sequencer phases and peripheral operations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_RESET = 4'b0001,
        PH_WAIT = 4'b0010,
        PH_RUN = 4'b0100,
        PH_STOP = 4'b1000
    } mrs_phase_t;

    typedef enum logic [1:0] {
        POP_MOVW = 2'h0,
        POP_MOVR = 2'h1,
        POP_AND = 2'h2,
        POP_OR = 2'h3
    } mrs_pop_t;

    typedef struct packed {
        logic valid;
        mrs_pop_t op;
        logic [7:0] data;
    } mrs_preq_t;

endpackage : mrs_pkg

// ### rtl/mrs_top.sv
// Reset merge, start-up wait and reset-state loader for the core
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - First instruction runs exactly 1866 cycles after internal reset falls.
// - Supply rising past the threshold makes a 50 us internal reset pulse.
// - Oscillator is inhibited while supply is low and after stop.
// - Reset clears program counter, banks and stack pointer to zero.
// - Reset disables interrupts, stops and clears timer and its flag.
// - Reset sets prescaler select to zero, dividing by 32.
// - Reset loads each port flip-flop from a per-line build option.
// - Reset cancels idle and stop modes.
// - Peripheral registers are reached through a peripheral address register.
// - A build option removes the power-on circuit; only the pin and the software reset bit then reset.
// - Idle with no enabled interrupt ends only by internal reset: pin, power-on or software reset.
module mrs_top
    import mrs_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_PULSE_CYC,
    parameter bit POR_PRESENT = 1'b1,
    parameter logic [19:0] PORT_SET_MASK = 20'hfffff,
    parameter int unsigned NPREG = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus, AXI4-Lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Supply and pins
    input wire logic supply_ok,
    input wire logic rst_pin,
    input wire logic wake_pin,
    // Core side
    input wire logic stop_exec,
    input wire logic idle_exec,
    input wire logic [2:0] irq_pending,
    input wire logic state_we,
    input wire mrs_core_state_t state_in,
    input wire logic port_we,
    input wire logic [19:0] port_in,
    input wire logic pa_we,
    input wire logic [7:0] pa_data,
    input wire mrs_preq_t preq,
    // Sequencer outputs
    output logic core_reset_q,
    output logic core_run_q,
    output logic idle_q,
    output logic stop_q,
    output logic osc_enable_q,
    output mrs_core_state_t core_state_q,
    output logic [19:0] port_ff_q,
    output logic [7:0] prd_data_q,
    output logic prd_valid_q
);

    localparam int unsigned PIDX_W = $clog2(NPREG);

    // ------------------------------------------------------------
    // Reset merge
    // ------------------------------------------------------------
    logic pin_s1_q, pin_s2_q, supply_q, por_active_q, int_rst_q, sw_rst_q;
    logic pin_s1_d, pin_s2_d, supply_d, por_active_d, int_rst_d;
    logic [POR_W-1:0] por_cnt_q, por_cnt_d;

    // Power-on pulse on supply rise; pin through two flops
    always_comb begin
        pin_s1_d = rst_pin;
        pin_s2_d = pin_s1_q;
        supply_d = supply_ok;
        por_cnt_d = (por_cnt_q != '0) ? por_cnt_q - 1'b1 : por_cnt_q;
        if (POR_PRESENT && supply_ok && !supply_q) begin
            por_cnt_d = POR_W'(POR_CYCLES);
        end
        // Low supply also holds reset; absent circuit never fires
        por_active_d = POR_PRESENT && (!supply_ok || por_cnt_d != '0);
        int_rst_d = por_active_q | pin_s2_q | sw_rst_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            supply_q <= 1'b0;
            por_cnt_q <= '0;
            por_active_q <= 1'b1;
            int_rst_q <= 1'b1;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            supply_q <= supply_d;
            por_cnt_q <= por_cnt_d;
            por_active_q <= por_active_d;
            int_rst_q <= int_rst_d;
        end
    end

    // ------------------------------------------------------------
    // Phase sequencer and low-power modes
    // ------------------------------------------------------------
    mrs_phase_t phase_q, phase_d;
    logic [WAIT_W-1:0] wait_q, wait_d;
    logic idle_d, run_d, osc_d;
    logic irq_wake;

    // The aclk keeps running; osc_enable_q tells the analog part to stop
    always_comb begin
        phase_d = phase_q;
        wait_d = wait_q;
        idle_d = idle_q;
        irq_wake = |(irq_pending & core_state_q.int_en);
        unique case (phase_q)
            PH_RESET: begin
                if (!int_rst_q) begin
                    phase_d = PH_WAIT;
                    wait_d = WAIT_LOAD;
                end
            end
            PH_WAIT: begin
                if (wait_q == '0) phase_d = PH_RUN;
                else wait_d = wait_q - 1'b1;
            end
            PH_RUN: begin
                if (idle_q && irq_wake) idle_d = 1'b0;
                else if (idle_exec) idle_d = 1'b1;
                // A high wake pin blocks entry into stop
                if (stop_exec && !wake_pin && !idle_q) phase_d = PH_STOP;
            end
            PH_STOP: begin
                if (wake_pin) begin
                    phase_d = PH_WAIT;
                    wait_d = WAIT_LOAD;
                end
            end
            default: phase_d = PH_RESET;
        endcase
        if (int_rst_q) begin
            phase_d = PH_RESET;
            idle_d = 1'b0;
        end
        run_d = (phase_d == PH_RUN);
        osc_d = supply_ok && (phase_d != PH_STOP);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= PH_RESET;
            wait_q <= '0;
            idle_q <= 1'b0;
            stop_q <= 1'b0;
            core_run_q <= 1'b0;
            osc_enable_q <= 1'b0;
            core_reset_q <= 1'b1;
        end else begin
            phase_q <= phase_d;
            wait_q <= wait_d;
            idle_q <= idle_d;
            stop_q <= (phase_d == PH_STOP);
            core_run_q <= run_d;
            osc_enable_q <= osc_d;
            core_reset_q <= int_rst_d;
        end
    end

    // ------------------------------------------------------------
    // Core state, ports and peripheral address
    // ------------------------------------------------------------
    mrs_core_state_t state_d;
    logic [19:0] port_d;
    logic [7:0] paddr_q, paddr_d;

    // Held at reset values for as long as internal reset stands
    always_comb begin
        state_d = state_we ? state_in : core_state_q;
        port_d = port_we ? port_in : port_ff_q;
        paddr_d = pa_we ? pa_data : paddr_q;
        if (int_rst_q) begin
            state_d = CORE_STATE_RST;
            port_d = PORT_SET_MASK;
            paddr_d = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_state_q <= CORE_STATE_RST;
            port_ff_q <= PORT_SET_MASK;
            paddr_q <= 8'h00;
        end else begin
            core_state_q <= state_d;
            port_ff_q <= port_d;
            paddr_q <= paddr_d;
        end
    end

    // Unmapped peripheral addresses are silently dropped
    mrs_periph_mem #(
        .N(NPREG)
    ) u_pmem (
        .aclk(aclk),
        .aresetn(aresetn),
        .req_valid(preq.valid && paddr_q < 8'(NPREG)),
        .req_op(preq.op),
        .req_idx(paddr_q[PIDX_W-1:0]),
        .req_data(preq.data),
        .rdata_q(prd_data_q),
        .rvalid_q(prd_valid_q)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d, sw_rst_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d, wdat_q, wdat_d;
    logic [7:0] waddr_q, waddr_d;
    logic wstb_q, wstb_d;
    logic aw_got, w_got;

    // Address and data in either order; answer one cycle after both
    always_comb begin
        awready_d = awready;
        wready_d = wready;
        bvalid_d = bvalid;
        bresp_d = bresp;
        arready_d = arready;
        rvalid_d = rvalid;
        rresp_d = rresp;
        rdata_d = rdata;
        waddr_d = waddr_q;
        wdat_d = wdat_q;
        wstb_d = wstb_q;
        sw_rst_d = sw_rst_q;
        if (awvalid && awready) begin
            awready_d = 1'b0;
            waddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wready_d = 1'b0;
            wdat_d = wdata;
            wstb_d = wstrb[0];
        end
        aw_got = !awready_d;
        w_got = !wready_d;
        if (aw_got && w_got && !bvalid) begin
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            // Software reset is a held level, not a pulse
            if (waddr_d == ADDR_CTRL) begin
                if (wstb_d) sw_rst_d = wdat_d[CTRL_SWRST_BIT];
            end else if (waddr_d != ADDR_STATUS && waddr_d != ADDR_WAIT
                         && waddr_d != ADDR_PADDR) begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (bvalid && bready) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        if (arvalid && arready) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (araddr)
                ADDR_CTRL: rdata_d[CTRL_SWRST_BIT] = sw_rst_q;
                ADDR_STATUS: rdata_d[6:0] = {pin_s2_q, por_active_q,
                    osc_enable_q, stop_q, idle_q, core_run_q, core_reset_q};
                ADDR_WAIT: rdata_d[WAIT_W-1:0] = wait_q;
                ADDR_PADDR: rdata_d[7:0] = paddr_q;
                default: rresp_d = RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            waddr_q <= 8'h00;
            wdat_q <= 32'h0000_0000;
            wstb_q <= 1'b0;
            sw_rst_q <= 1'b0;
        end else begin
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rresp <= rresp_d;
            rdata <= rdata_d;
            waddr_q <= waddr_d;
            wdat_q <= wdat_d;
            wstb_q <= wstb_d;
            sw_rst_q <= sw_rst_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int WAIT_SPAN = OSC_WAIT_CYC - 1;
    logic [WAIT_W:0] wait_h;
    logic [POR_W:0] por_h;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_h <= '0;
            por_h <= '0;
        end else begin
            wait_h <= (phase_q == PH_WAIT) ? wait_h + 1'b1 : '0;
            por_h <= por_active_q ? por_h + 1'b1 : '0;
        end
    end

    property p_wait_exact;
        @(posedge aclk) disable iff (!aresetn)
        $rose(core_run_q) |-> wait_h == (WAIT_W+1)'(WAIT_SPAN);
    endproperty
    a_wait_exact: assert property (p_wait_exact)
        else $error("run did not start 1866 cycles after wait began");

    property p_fall_to_wait;
        @(posedge aclk) disable iff (!aresetn)
        $fell(core_reset_q) |-> ##1 phase_q == PH_WAIT ##1 !core_run_q;
    endproperty
    a_fall_to_wait: assert property (p_fall_to_wait)
        else $error("start-up wait not entered after reset fell");

    property p_por_len;
        @(posedge aclk) disable iff (!aresetn)
        $fell(por_active_q) |-> por_h >= (POR_W+1)'(POR_CYCLES);
    endproperty
    a_por_len: assert property (p_por_len)
        else $error("power-on pulse shorter than its count");

    property p_por_none;
        @(posedge aclk) disable iff (!aresetn)
        !POR_PRESENT && !rst_pin [*3] ##1 !sw_rst_q [*2] |=> !core_reset_q;
    endproperty
    a_por_none: assert property (p_por_none)
        else $error("reset without pin when power-on circuit absent");

    property p_osc;
        @(posedge aclk) disable iff (!aresetn)
        !supply_ok || (phase_q == PH_RUN && stop_exec && !wake_pin
                       && !idle_q && !int_rst_q) |=> !osc_enable_q;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator enabled during low supply or stop");

    property p_state_rst;
        @(posedge aclk) disable iff (!aresetn)
        core_reset_q ##1 core_reset_q |=> core_state_q == CORE_STATE_RST
            && port_ff_q == PORT_SET_MASK;
    endproperty
    a_state_rst: assert property (p_state_rst)
        else $error("core state or ports not at reset values");

    property p_modes_cancel;
        @(posedge aclk) disable iff (!aresetn)
        core_reset_q |=> !idle_q && !stop_q && !core_run_q;
    endproperty
    a_modes_cancel: assert property (p_modes_cancel)
        else $error("low-power mode survived reset");

    property p_idle_hold;
        @(posedge aclk) disable iff (!aresetn)
        idle_q && !irq_wake && !int_rst_q |=> idle_q;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle left without enabled interrupt or reset");

    property p_pin_sync;
        @(posedge aclk) disable iff (!aresetn)
        rst_pin |-> ##3 core_reset_q;
    endproperty
    a_pin_sync: assert property (p_pin_sync)
        else $error("reset pin not reflected three cycles later");

    property p_periph_rd;
        @(posedge aclk) disable iff (!aresetn)
        preq.valid && preq.op == POP_MOVR && paddr_q < 8'(NPREG)
            |=> prd_valid_q;
    endproperty
    a_periph_rd: assert property (p_periph_rd)
        else $error("peripheral read gave no answer");

endmodule : mrs_top
